// *** common/iad_cfg.svh ***
// Constants for the interleave address decode block.
// Assumes a 40 MHz system clock and a bus whose pins are asynchronous to it.
`ifndef IAD_CFG_SVH
`define IAD_CFG_SVH

`define IAD_CLK_NS 25
`define IAD_T_ACCESS_NS 400
`define IAD_T_RELEASE_NS 600
`define IAD_T_TAIL_NS 300
// Slave sync rises one clock inside the access limit, so read data are strictly early.
`define IAD_ACCESS_CYC ((`IAD_T_ACCESS_NS / `IAD_CLK_NS) - 1)
`define IAD_CYCLE_CYC ((`IAD_T_RELEASE_NS + `IAD_T_TAIL_NS) / `IAD_CLK_NS)
`define IAD_CNT_W 6
`define IAD_ADDR_W 18
`define IAD_DATA_W 16
`define IAD_LOC_W 14
`define IAD_BLK_W 3
`define IAD_BIT_BYTE 0
`define IAD_BIT_WLSB 1
`define IAD_BIT_BLKLSB 15
`define IAD_BIT_LOC_HI 14
`define IAD_BIT_BLK_HI 17
`define IAD_CTL_WRITE 1
`define IAD_CTL_BYTE 0
`define IAD_BE_NONE 2'h0
`define IAD_BE_LOW 2'h1
`define IAD_BE_HIGH 2'h2
`define IAD_BE_BOTH 2'h3

`endif

// *** common/iad_pkg.sv ***
// Types for the interleave address decode block.
// Assumes iad_cfg.svh is on the include path.
`include "iad_cfg.svh"

package iad_pkg;

    typedef enum logic [3:0] {
        IAD_ST_IDLE = 4'h1,
        IAD_ST_ACCESS = 4'h2,
        IAD_ST_ACK = 4'h4,
        IAD_ST_TAIL = 4'h8
    } iad_state_t;

    typedef struct packed {
        logic [`IAD_LOC_W-1:0] loc;
        logic write;
        logic [1:0] byte_en;
    } iad_core_req_t;

    typedef struct packed {
        logic interleave;
        logic low_block;
        logic [`IAD_BLK_W-1:0] block;
    } iad_strap_t;

endpackage

// *** tb/iad_bus_master.sv ***
// Bus master model: one full handshake transfer per call of xfer.
// Assumes lines are asserted high and the bench calls xfer.
`timescale 1ns/100ps
`default_nettype none
`include "iad_cfg.svh"

module iad_bus_master
(
    input wire logic mclk_in,
    input wire logic ssyn_in,
    input wire logic [`IAD_DATA_W-1:0] rdata_in,
    output logic [`IAD_ADDR_W-1:0] addr_out,
    output logic [1:0] ctl_out,
    output logic msyn_out,
    output logic [`IAD_DATA_W-1:0] wdata_out
);
    initial
    begin
        addr_out = 18'h3FFFF;
        ctl_out = 2'h0;
        msyn_out = 1'b0;
        wdata_out = 16'h0;
    end
    // Released lines show the inverse of their last value.
    task automatic xfer(input logic [17:0] a, input logic [1:0] c, input logic [15:0] d,
        output logic ok, output logic [15:0] q);
        int n;
        @(negedge mclk_in);
        addr_out = a;
        ctl_out = c;
        wdata_out = d;
        repeat (6) @(negedge mclk_in);
        msyn_out = 1'b1;
        ok = 1'b0;
        for (n = 0; n < 40 && !ok; n++)
        begin
            @(posedge mclk_in);
            ok = (ssyn_in === 1'b1);
            q = rdata_in;
        end
        @(negedge mclk_in);
        msyn_out = 1'b0;
        for (n = 0; n < 12 && ssyn_in !== 1'b0; n++)
            @(posedge mclk_in);
        @(negedge mclk_in);
        addr_out = ~a;
        ctl_out = ~c;
        wdata_out = ~d;
    endtask
endmodule

`default_nettype wire

// *** tb/iad_core_bench.sv ***
// Bench for iad_core: decode, straps, interleave swap and cycle timing.
// Assumes the master model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "iad_cfg.svh"

module iad_core_bench
    import iad_pkg::*;
;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic bus_dclo_in = 1'b0;
    logic strap_interleave_in = 1'b0;
    logic low_block_strap_in = 1'b0;
    logic [2:0] strap_block_in = 3'h0;
    logic [17:0] bus_addr_in;
    logic [1:0] bus_ctl_in;
    logic bus_msyn_in, bus_data_oe_out, bus_ssyn_out, core_start_out, busy_out, il;
    logic [15:0] bus_data_in, bus_data_out, core_wr_data_out, core_rd_data_in, m_wd;
    iad_core_req_t core_req_out;
    int fail_count = 0;
    int checked = 0;
    int starts = 0;
    initial forever #12.5 mclk_in = ~mclk_in;
    assign bus_data_in = bus_data_oe_out ? bus_data_out : m_wd;
    assign core_rd_data_in = {2'h2, core_req_out.loc} ^ 16'hA5C3;
    always @(posedge mclk_in) if (core_start_out === 1'b1) starts++;
    iad_core dut (.mclk_in, .sys_rst_in, .ce_in(1'b1), .bus_addr_in, .bus_ctl_in, .bus_msyn_in,
        .bus_dclo_in, .bus_data_in, .bus_data_out, .bus_data_oe_out, .bus_ssyn_out,
        .strap_interleave_in, .low_block_strap_in, .strap_block_in, .core_start_out,
        .core_req_out, .core_wr_data_out, .core_rd_data_in, .busy_out);
    iad_bus_master m (.mclk_in, .ssyn_in(bus_ssyn_out), .rdata_in(bus_data_in), .addr_out(bus_addr_in),
        .ctl_out(bus_ctl_in), .msyn_out(bus_msyn_in), .wdata_out(m_wd));
    // ==========================================
    // Shared tasks.
    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic do_rst(input logic i, input logic lo, input logic [2:0] b);
        @(negedge mclk_in);
        sys_rst_in = 1'b1;
        strap_interleave_in = i;
        low_block_strap_in = lo;
        strap_block_in = b;
        il = i;
        repeat (16) @(negedge mclk_in);
        sys_rst_in = 1'b0;
        repeat (2) @(negedge mclk_in);
    endtask
    task automatic idle;
        for (int n = 0; n < 60 && busy_out !== 1'b0; n++)
            @(posedge mclk_in);
        chk(busy_out, 1'b0);
    endtask
    task automatic acc(input logic [17:0] a, input logic [1:0] c, input logic k);
        logic ok;
        logic [15:0] q, d;
        logic [13:0] l;
        int s0;
        s0 = starts;
        d = a[15:0] ^ 16'h3C96;
        l = il ? {a[14:2], a[15]} : a[14:1];
        m.xfer(a, c, d, ok, q);
        chk(ok, k);
        chk(17'(starts - s0), k);
        if (k)
        begin
            chk(core_req_out.loc, l);
            chk(core_req_out.byte_en, !c[1] ? 2'h0 : !c[0] ? 2'h3 : a[0] ? 2'h2 : 2'h1);
            chk(c[1] ? core_wr_data_out : q, c[1] ? d : {2'h2, l} ^ 16'hA5C3);
        end
        idle();
    endtask
    // ==========================================
    // Scenarios.
    task automatic t_plain;
        logic ok;
        logic [15:0] q;
        do_rst(1'b0, 1'b0, 3'h0);
        for (int c = 0; c < 4; c++)
            acc(18'h02AAE | 18'(c & 1), 2'(c), 1'b1);
        acc(18'h0A000, 2'h0, 1'b0);
        acc(18'h27FFE, 2'h2, 1'b0);
        m.xfer(18'h00010, 2'h0, 16'h0, ok, q);
        chk(busy_out, 1'b1);
        acc(18'h00012, 2'h0, 1'b1);
        @(negedge mclk_in);
        bus_dclo_in = 1'b1;
        acc(18'h00014, 2'h0, 1'b0);
        @(negedge mclk_in);
        bus_dclo_in = 1'b0;
        $display("plain decode test done");
    endtask
    task automatic t_straps;
        do_rst(1'b1, 1'b0, 3'h0);
        acc(18'h00004, 2'h0, 1'b1);
        acc(18'h08000, 2'h2, 1'b1);
        acc(18'h00002, 2'h0, 1'b0);
        do_rst(1'b0, 1'b1, 3'h0);
        acc(18'h08002, 2'h2, 1'b1);
        acc(18'h00002, 2'h0, 1'b0);
        do_rst(1'b1, 1'b1, 3'h0);
        acc(18'h00002, 2'h0, 1'b1);
        acc(18'h0800A, 2'h3, 1'b1);
        acc(18'h00004, 2'h0, 1'b0);
        do_rst(1'b0, 1'b0, 3'h5);
        acc(18'h28004, 2'h0, 1'b1);
        acc(18'h00004, 2'h2, 1'b0);
        $display("strap test done");
    endtask
    initial
    begin
        t_plain();
        t_straps();
        end_sim();
    end
endmodule

`default_nettype wire

// *** tb/iad_core_properties.sv ***
// Timing checks on the bus and core ports of iad_core.
// Assumes it is bound to iad_core and that bus lines are asserted high.
`timescale 1ns/100ps
`default_nettype none
`include "iad_cfg.svh"

module iad_core_properties
    import iad_pkg::*;
(
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic bus_msyn_in,
    input wire logic bus_dclo_in,
    input wire logic bus_ssyn_out,
    input wire logic bus_data_oe_out,
    input wire logic core_start_out,
    input wire iad_core_req_t core_req_out,
    input wire logic [`IAD_DATA_W-1:0] core_wr_data_out,
    input wire logic busy_out
);
    // ==========================================
    // Cycles since the last core start.
    logic [5:0] age_ff;
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in || core_start_out)
            age_ff <= 6'h0;
        else if (age_ff != 6'h3F)
            age_ff <= age_ff + 6'h1;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    // ==========================================
    // Assertions.
    property p_idle_start;
        core_start_out |-> !$past(busy_out) && busy_out;
    endproperty
    a_idle_start: assert property (p_idle_start) else $error("start while busy");
    property p_access;
        core_start_out |-> !bus_ssyn_out[*8] ##1 !bus_ssyn_out[*7] ##1 $rose(bus_ssyn_out);
    endproperty
    a_access: assert property (p_access) else $error("ssyn not at access point");
    property p_busy_len;
        $fell(busy_out) |-> age_ff >= 6'h22;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy ended early");
    property p_ssyn_hold;
        bus_msyn_in[*6] ##0 bus_ssyn_out |=> bus_ssyn_out;
    endproperty
    a_ssyn_hold: assert property (p_ssyn_hold) else $error("ssyn dropped under msyn");
    property p_ssyn_drop;
        $fell(bus_msyn_in) ##0 bus_ssyn_out |-> ##[1:10] !bus_ssyn_out;
    endproperty
    a_ssyn_drop: assert property (p_ssyn_drop) else $error("ssyn not cleared");
    property p_oe;
        bus_data_oe_out |-> bus_ssyn_out && !core_req_out.write;
    endproperty
    a_oe: assert property (p_oe) else $error("data driven outside read ack");
    property p_dclo;
        bus_dclo_in[*8] |=> !core_start_out;
    endproperty
    a_dclo: assert property (p_dclo) else $error("start under dc low");
    property p_hold;
        !core_start_out |-> $stable(core_req_out) && $stable(core_wr_data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("core request changed");
endmodule

bind iad_core iad_core_properties u_props (.mclk_in, .sys_rst_in, .bus_msyn_in, .bus_dclo_in,
    .bus_ssyn_out, .bus_data_oe_out, .core_start_out, .core_req_out, .core_wr_data_out, .busy_out);

`default_nettype wire

// *** verilog/iad_core.sv ***
// Address block select, interleave swap and cycle timing of a 16K-word memory module.
// Assumes bus pins are asynchronous, presented active high, and that straps are static.
`timescale 1ns/100ps
`default_nettype none
`include "iad_cfg.svh"

module iad_core
    import iad_pkg::*;
(
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic [`IAD_ADDR_W-1:0] bus_addr_in,
    input wire logic [1:0] bus_ctl_in,
    input wire logic bus_msyn_in,
    input wire logic bus_dclo_in,
    input wire logic [`IAD_DATA_W-1:0] bus_data_in,
    output logic [`IAD_DATA_W-1:0] bus_data_out,
    output logic bus_data_oe_out,
    output logic bus_ssyn_out,
    input wire logic strap_interleave_in,
    input wire logic low_block_strap_in,
    input wire logic [`IAD_BLK_W-1:0] strap_block_in,
    output logic core_start_out,
    output iad_core_req_t core_req_out,
    output logic [`IAD_DATA_W-1:0] core_wr_data_out,
    input wire logic [`IAD_DATA_W-1:0] core_rd_data_in,
    output logic busy_out
);

    localparam int SYNC_W = `IAD_ADDR_W + 2 + 1 + 1 + `IAD_DATA_W;

    // ==========================================================
    // Pin synchronisers
    logic [SYNC_W-1:0] sync_bus;
    logic [`IAD_ADDR_W-1:0] addr_s;
    logic [1:0] ctl_s;
    logic msyn_s;
    logic dclo_s;
    logic [`IAD_DATA_W-1:0] data_s;

    iad_sync3 #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .pin_in({bus_addr_in, bus_ctl_in, bus_msyn_in, bus_dclo_in, bus_data_in}),
        .sync_out(sync_bus)
    );

    assign {addr_s, ctl_s, msyn_s, dclo_s, data_s} = sync_bus;

    // ==========================================================
    // Strap capture
    iad_strap_t strap_ff;

    // Straps are taken while reset is held and then frozen.
    // static swap
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            strap_ff <= '{interleave: strap_interleave_in, low_block: low_block_strap_in,
                          block: strap_block_in};
        end
    end

    // ==========================================================
    // Address decode
    function automatic logic [`IAD_ADDR_W-1:0] swap_addr(input logic [`IAD_ADDR_W-1:0] a, input logic en);
        logic [`IAD_ADDR_W-1:0] r;
        r = a;
        if (en)
        begin
            r[`IAD_BIT_WLSB] = a[`IAD_BIT_BLKLSB];
            r[`IAD_BIT_BLKLSB] = a[`IAD_BIT_WLSB];
        end
        return r;
    endfunction

    logic [`IAD_ADDR_W-1:0] dec_addr;
    logic [`IAD_LOC_W-1:0] dec_loc;
    logic [`IAD_BLK_W-1:0] dec_blk;
    logic [`IAD_BLK_W-1:0] own_blk;
    logic in_block;

    assign dec_addr = swap_addr(addr_s, strap_ff.interleave);
    assign dec_loc = dec_addr[`IAD_BIT_LOC_HI:`IAD_BIT_WLSB];
    assign dec_blk = dec_addr[`IAD_BIT_BLK_HI:`IAD_BIT_BLKLSB];
    assign own_blk = {strap_ff.block[`IAD_BLK_W-1:1], strap_ff.block[0] | strap_ff.low_block};
    assign in_block = (dec_blk == own_blk);

    // ==========================================================
    // Command decode
    logic is_write;
    logic [1:0] byte_en;

    assign is_write = ctl_s[`IAD_CTL_WRITE];
    assign byte_en = !is_write ? `IAD_BE_NONE :
                     !ctl_s[`IAD_CTL_BYTE] ? `IAD_BE_BOTH :
                     addr_s[`IAD_BIT_BYTE] ? `IAD_BE_HIGH : `IAD_BE_LOW;

    // ==========================================================
    // Cycle sequencer
    iad_state_t state_ff;
    iad_state_t nxt_state;
    logic [`IAD_CNT_W-1:0] cnt_ff;
    logic start;
    logic access_done;
    logic cycle_done;
    logic ssyn_ff;
    logic oe_ff;
    logic [`IAD_DATA_W-1:0] rd_ff;
    iad_core_req_t req_ff;
    logic [`IAD_DATA_W-1:0] wr_ff;
    logic start_ff;

    assign start = (state_ff == IAD_ST_IDLE) && msyn_s && in_block && !ssyn_ff && !dclo_s;
    assign access_done = (cnt_ff >= `IAD_CNT_W'(`IAD_ACCESS_CYC - 1));
    assign cycle_done = (cnt_ff >= `IAD_CNT_W'(`IAD_CYCLE_CYC - 1));

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            IAD_ST_IDLE:
            begin
                if (start)
                begin
                    nxt_state = IAD_ST_ACCESS;
                end
            end
            IAD_ST_ACCESS:
            begin
                if (access_done)
                begin
                    nxt_state = IAD_ST_ACK;
                end
            end
            IAD_ST_ACK:
            begin
                if (!msyn_s)
                begin
                    nxt_state = IAD_ST_TAIL;
                end
            end
            IAD_ST_TAIL:
            begin
                if (cycle_done)
                begin
                    nxt_state = IAD_ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = IAD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            state_ff <= IAD_ST_IDLE;
            cnt_ff <= '0;
        end
        else if (ce_in)
        begin
            state_ff <= nxt_state;
            if (start)
            begin
                cnt_ff <= '0;
            end
            else if (state_ff != IAD_ST_IDLE && !cycle_done)
            begin
                cnt_ff <= cnt_ff + `IAD_CNT_W'(1);
            end
        end
    end

    // Slave sync is raised as the access completes and dropped when master sync goes away.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            ssyn_ff <= 1'b0;
            oe_ff <= 1'b0;
            rd_ff <= '0;
            req_ff <= '0;
            wr_ff <= '0;
            start_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            start_ff <= start;
            if (start)
            begin
                req_ff <= '{loc: dec_loc, write: is_write, byte_en: byte_en};
                wr_ff <= data_s;
            end
            if (state_ff == IAD_ST_ACCESS && access_done)
            begin
                ssyn_ff <= 1'b1;
                oe_ff <= !req_ff.write;
                rd_ff <= core_rd_data_in;
            end
            else if (state_ff == IAD_ST_ACK && !msyn_s)
            begin
                ssyn_ff <= 1'b0;
                oe_ff <= 1'b0;
            end
        end
    end

    assign bus_ssyn_out = ssyn_ff;
    assign bus_data_oe_out = oe_ff;
    assign bus_data_out = rd_ff;
    assign core_start_out = start_ff;
    assign core_req_out = req_ff;
    assign core_wr_data_out = wr_ff;
    assign busy_out = (state_ff != IAD_ST_IDLE);

endmodule

`default_nettype wire

// *** verilog/iad_sync3.sv ***
// Three-stage pin synchroniser with agreement filter.
// Assumes its input is asynchronous to mclk_in.
`timescale 1ns/100ps
`default_nettype none

module iad_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] hold_ff;
    logic [WIDTH-1:0] nxt_hold;

    // A bit changes only once the second and third stages agree.
    assign nxt_hold = (s2_ff & s3_ff) | (hold_ff & (s2_ff | s3_ff));

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            hold_ff <= '0;
        end
        else if (ce_in)
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            hold_ff <= nxt_hold;
        end
    end

    assign sync_out = hold_ff;

endmodule

`default_nettype wire
